/* src/adc_control_sequencer.sv */
// Converter control sequencer: registers, start handshake, clock divider
`timescale 1ns/1ps
`default_nettype none

module adc_control_sequencer (
	input  wire logic                           clock,
	input  wire logic                           arst_n,
	input  wire logic [2:0]                     reg_addr,
	input  wire logic [7:0]                     reg_wdata,
	input  wire logic                           reg_write,
	input  wire logic                           reg_read,
	output logic      [7:0]                     reg_rdata,
	input  wire logic                           core_bit,
	input  wire logic [7:0]                     pin_analog_select,
	output logic      [7:0]                     pin_digital_disable,
	output logic                                converter_enable,
	output logic                                converter_reset,
	output logic                                converter_clock,
	output logic                                sample_phase,
	output logic                                conversion_busy_flag,
	output logic                                interrupt_request,
	output adc_control_pkg::input_route_type    input_route,
	output adc_control_pkg::ref_route_type      ref_route,
	output logic                                amplifier_enable,
	output logic                                bandgap_buffer_enable,
	output logic                                amp_input_bandgap
);
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RESET = 3'b010,
		ST_RUN   = 3'b100
	} seq_state_type;

	logic [1:0]  rst_sync_reg;
	logic        rst_n;
	logic [7:0]  ctrl_reg;
	logic [7:0]  src_clk_reg;
	logic [7:0]  ref_amp_reg;
	logic [11:0] result_reg;
	logic [11:0] shift_reg;
	logic [2:0]  core_sync_reg;
	logic        core_bit_stable_reg;
	logic [6:0]  div_count_reg;
	logic        tick_reg;
	logic [4:0]  clk_count_reg;
	seq_state_type state_reg;
	logic        start_prev_reg;
	logic        start_rise;
	logic        start_fall;
	logic        conv_done;
	logic [7:0]  div_limit;
	logic [7:0]  result_low;
	logic [7:0]  result_high;

	assign rst_n = rst_sync_reg[1];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	// Software writes; busy position masked off so writes cannot touch it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg    <= adc_control_pkg::CTRL_RESET;
			src_clk_reg <= adc_control_pkg::CTRL_RESET;
			ref_amp_reg <= adc_control_pkg::CTRL_RESET;
		end else if (reg_write) begin
			unique case (reg_addr)
				adc_control_pkg::ADDR_CTRL_MAIN:
					ctrl_reg <= reg_wdata & adc_control_pkg::CTRL_MAIN_MASK;
				adc_control_pkg::ADDR_SRC_CLK:
					src_clk_reg <= reg_wdata & adc_control_pkg::SRC_CLK_MASK;
				adc_control_pkg::ADDR_REF_AMP:
					ref_amp_reg <= reg_wdata & adc_control_pkg::REF_AMP_MASK;
				default: ;
			endcase
		end
	end

	assign start_rise = ctrl_reg[adc_control_pkg::START_BIT] & ~start_prev_reg;
	assign start_fall = ~ctrl_reg[adc_control_pkg::START_BIT] & start_prev_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			start_prev_reg <= 1'b0;
		end else begin
			start_prev_reg <= ctrl_reg[adc_control_pkg::START_BIT];
		end
	end

	// Divider: 2**field system clocks per converter clock tick
	always_comb begin
		div_limit = 8'h00;
		div_limit[src_clk_reg[2:0]] = 1'b1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_count_reg <= 7'h00;
			tick_reg      <= 1'b0;
		end else if (!ctrl_reg[adc_control_pkg::ENABLE_BIT]) begin
			div_count_reg <= 7'h00;
			tick_reg      <= 1'b0;
		end else if ({1'b0, div_count_reg} + 8'h01 >= div_limit) begin
			div_count_reg <= 7'h00;
			tick_reg      <= 1'b1;
		end else begin
			div_count_reg <= div_count_reg + 7'h01;
			tick_reg      <= 1'b0;
		end
	end

	// Core returns result serially, MSB first, during converting clocks
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core_sync_reg       <= 3'h0;
			core_bit_stable_reg <= 1'b0;
		end else begin
			core_sync_reg <= {core_sync_reg[1:0], core_bit};
			if (core_sync_reg[1] == core_sync_reg[2]) begin
				core_bit_stable_reg <= core_sync_reg[2];
			end
		end
	end

	// Enable gate stops a stale tick finishing a conversion being disabled
	assign conv_done = (state_reg == ST_RUN) && tick_reg
		&& ctrl_reg[adc_control_pkg::ENABLE_BIT]
		&& (clk_count_reg == adc_control_pkg::TOTAL_CLOCKS - 5'h01);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg     <= ST_IDLE;
			clk_count_reg <= 5'h00;
			shift_reg     <= 12'h000;
		end else if (!ctrl_reg[adc_control_pkg::ENABLE_BIT]) begin
			state_reg     <= ST_IDLE;
			clk_count_reg <= 5'h00;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start_rise) begin
						state_reg <= ST_RESET;
					end
				end
				ST_RESET: begin
					if (start_fall) begin
						state_reg     <= ST_RUN;
						clk_count_reg <= 5'h00;
					end
				end
				ST_RUN: begin
					if (start_rise) begin
						state_reg <= ST_RESET;
					end else if (tick_reg) begin
						clk_count_reg <= clk_count_reg + 5'h01;
						if (clk_count_reg >= 5'(adc_control_pkg::SAMPLE_CLOCKS)) begin
							shift_reg <= {shift_reg[10:0], core_bit_stable_reg};
						end
						if (conv_done) begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Result survives disable; only a finished conversion updates it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			result_reg <= 12'h000;
		end else if (conv_done) begin
			result_reg <= {shift_reg[10:0], core_bit_stable_reg};
		end
	end

	always_comb begin
		if (ctrl_reg[adc_control_pkg::ALIGN_BIT]) begin
			result_high = {4'h0, result_reg[11:8]};
			result_low  = result_reg[7:0];
		end else begin
			result_high = result_reg[11:4];
			result_low  = {result_reg[3:0], 4'h0};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_read) begin
			unique case (reg_addr)
				adc_control_pkg::ADDR_RESULT_LOW:  reg_rdata <= result_low;
				adc_control_pkg::ADDR_RESULT_HIGH: reg_rdata <= result_high;
				adc_control_pkg::ADDR_CTRL_MAIN:
					reg_rdata <= ctrl_reg | {1'b0, state_reg == ST_RUN, 6'h00};
				adc_control_pkg::ADDR_SRC_CLK:     reg_rdata <= src_clk_reg;
				adc_control_pkg::ADDR_REF_AMP:     reg_rdata <= ref_amp_reg;
				default:                           reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Status and control outputs, all registered
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			converter_enable     <= 1'b0;
			converter_reset      <= 1'b1;
			converter_clock      <= 1'b0;
			sample_phase         <= 1'b0;
			conversion_busy_flag <= 1'b0;
			interrupt_request    <= 1'b0;
		end else begin
			converter_enable     <= ctrl_reg[adc_control_pkg::ENABLE_BIT];
			converter_reset      <= state_reg == ST_RESET;
			converter_clock      <= tick_reg && state_reg == ST_RUN;
			sample_phase         <= state_reg == ST_RUN
				&& clk_count_reg < 5'(adc_control_pkg::SAMPLE_CLOCKS);
			conversion_busy_flag <= state_reg == ST_RUN && !conv_done;
			interrupt_request    <= conv_done;
		end
	end

	// Source and reference routing
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			input_route           <= '0;
			ref_route             <= '0;
			amplifier_enable      <= 1'b0;
			bandgap_buffer_enable <= 1'b0;
			amp_input_bandgap     <= 1'b0;
			pin_digital_disable   <= 8'h00;
		end else begin
			input_route.channel <= ctrl_reg[2:0];
			unique case (src_clk_reg[7:5])
				3'h1, 3'h2, 3'h3: begin
					input_route.kind       <= adc_control_pkg::SRC_SUPPLY;
					input_route.scale_log2 <= src_clk_reg[6:5] - 2'h1;
				end
				3'h5, 3'h6, 3'h7: begin
					input_route.kind       <= adc_control_pkg::SRC_AMP;
					input_route.scale_log2 <= src_clk_reg[6:5] - 2'h1;
				end
				default: begin
					input_route.kind       <= adc_control_pkg::SRC_EXTERNAL;
					input_route.scale_log2 <= 2'h0;
				end
			endcase
			ref_route.prohibited <= ref_amp_reg[3:0] == 4'h9;
			unique case (ref_amp_reg[3:0])
				4'h1, 4'h2, 4'h3, 4'h4: begin
					ref_route.kind       <= adc_control_pkg::REF_EXTERNAL;
					ref_route.multiplier <= ref_amp_reg[2:0];
				end
				4'hA, 4'hB, 4'hC: begin
					ref_route.kind       <= adc_control_pkg::REF_BANDGAP;
					ref_route.multiplier <= ref_amp_reg[2:0] - 3'h0;
				end
				default: begin
					ref_route.kind       <= adc_control_pkg::REF_SUPPLY;
					ref_route.multiplier <= 3'h1;
				end
			endcase
			amplifier_enable      <= ref_amp_reg[adc_control_pkg::AMP_EN_BIT];
			bandgap_buffer_enable <= ref_amp_reg[adc_control_pkg::BG_EN_BIT];
			amp_input_bandgap     <= ref_amp_reg[adc_control_pkg::REF_BG_BIT];
			pin_digital_disable   <= pin_analog_select;
		end
	end

	chk_busy_clears_done: assert property (@(posedge clock)
		disable iff (!rst_n)
		conv_done |=> !conversion_busy_flag && interrupt_request)
		else $error("busy not cleared or no request at end of conversion");
	chk_fall_sets_busy: assert property (@(posedge clock)
		disable iff (!rst_n) state_reg == ST_RESET && start_fall
		&& ctrl_reg[5] |=> ##1 conversion_busy_flag)
		else $error("busy not set after start fall");
	chk_rise_resets: assert property (@(posedge clock)
		disable iff (!rst_n) start_rise && ctrl_reg[5]
		|=> ##1 converter_reset && !conversion_busy_flag)
		else $error("start rise did not reset converter");
	chk_align_right: assert property (@(posedge clock)
		disable iff (!rst_n) reg_read && reg_addr == 3'h1
		&& ctrl_reg[4] |=> reg_rdata[7:4] == 4'h0)
		else $error("unused high result bits not zero");
	chk_align_left: assert property (@(posedge clock)
		disable iff (!rst_n) reg_read && reg_addr == 3'h1
		&& !ctrl_reg[4] |=> reg_rdata == 8'($past(result_reg) >> 4))
		else $error("left aligned high byte wrong");
	chk_disable_idle: assert property (@(posedge clock)
		disable iff (!rst_n)
		!ctrl_reg[5] |=> state_reg == ST_IDLE)
		else $error("converter ran while disabled");
	chk_result_kept: assert property (@(posedge clock)
		disable iff (!rst_n)
		!conv_done |=> $stable(result_reg))
		else $error("result changed without a conversion");
	chk_busy_read_only: assert property (@(posedge clock)
		disable iff (!rst_n) reg_write && reg_addr == 3'h2
		|=> !ctrl_reg[6] && ctrl_reg[5] == $past(reg_wdata[5]))
		else $error("busy bit written or enable bit not written");
	chk_clock_divide: assert property (@(posedge clock)
		disable iff (!rst_n) src_clk_reg[2:0] == 3'h1
		&& $stable(src_clk_reg) && tick_reg |=> !tick_reg)
		else $error("divide by two ticked twice in a row");
	chk_bandgap_feed: assert property (@(posedge clock)
		disable iff (!rst_n)
		ref_amp_reg[3] |=> amp_input_bandgap)
		else $error("bandgap not fed to amplifier");
	chk_internal_wins: assert property (@(posedge clock)
		disable iff (!rst_n) src_clk_reg[6:5] != 2'h0
		|=> input_route.kind != adc_control_pkg::SRC_EXTERNAL)
		else $error("internal source did not win");
	chk_external_only: assert property (@(posedge clock)
		disable iff (!rst_n) src_clk_reg[6:5] == 2'h0
		|=> input_route.kind == adc_control_pkg::SRC_EXTERNAL)
		else $error("pins not selected for source code zero");
	chk_bandgap_wins: assert property (@(posedge clock)
		disable iff (!rst_n) ref_amp_reg[3:0] inside {4'hA, 4'hB, 4'hC}
		|=> ref_route.kind == adc_control_pkg::REF_BANDGAP)
		else $error("bandgap reference not chosen");
	chk_ref_prohibit: assert property (@(posedge clock)
		disable iff (!rst_n) ref_amp_reg[3:0] == 4'h9
		|=> ref_route.prohibited && ref_route.multiplier == 3'h1)
		else $error("prohibited reference code not flagged");
	chk_bandgap_off: assert property (@(posedge clock)
		disable iff (!rst_n) !ref_amp_reg[adc_control_pkg::BG_EN_BIT]
		|=> !bandgap_buffer_enable)
		else $error("bandgap buffer on while its bit is clear");
	chk_pin_takeover: assert property (@(posedge clock)
		disable iff (!rst_n) $changed(pin_analog_select)
		|=> pin_digital_disable == $past(pin_analog_select))
		else $error("analog pin kept its digital function");
	chk_sample_window: assert property (@(posedge clock)
		disable iff (!rst_n) clk_count_reg[4:2] != 3'h0
		|=> !sample_phase)
		else $error("sampling ran past four converter clocks");
	chk_busy_spans: assert property (@(posedge clock)
		disable iff (!rst_n) state_reg == ST_RUN && !conv_done
		|=> conversion_busy_flag)
		else $error("busy dropped during conversion");
	chk_right_low: assert property (@(posedge clock)
		disable iff (!rst_n) reg_read && reg_addr == 3'h0
		&& ctrl_reg[4] |=> reg_rdata == 8'($past(result_reg)))
		else $error("right aligned low byte wrong");
	chk_start_holds: assert property (@(posedge clock)
		disable iff (!rst_n) state_reg == ST_RESET && ctrl_reg[7]
		|=> state_reg != ST_RUN)
		else $error("conversion began while start held high");
endmodule : adc_control_sequencer

`default_nettype wire

/* src/adc_control_pkg.sv */
// Package of register map, field layout and constants for the converter control
package adc_control_pkg;
	localparam logic [2:0] ADDR_RESULT_LOW  = 3'h0;
	localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
	localparam logic [2:0] ADDR_CTRL_MAIN   = 3'h2;
	localparam logic [2:0] ADDR_SRC_CLK     = 3'h3;
	localparam logic [2:0] ADDR_REF_AMP     = 3'h4;

	localparam int START_BIT      = 7;
	localparam int BUSY_BIT       = 6;
	localparam int ENABLE_BIT     = 5;
	localparam int ALIGN_BIT      = 4;
	localparam int AMP_EN_BIT     = 7;
	localparam int BG_EN_BIT      = 6;
	localparam int REF_BG_BIT     = 3;

	localparam logic [7:0] CTRL_MAIN_MASK = 8'hB7;
	localparam logic [7:0] SRC_CLK_MASK   = 8'hE7;
	localparam logic [7:0] REF_AMP_MASK   = 8'hCF;
	localparam logic [7:0] CTRL_RESET     = 8'h00;

	localparam int SAMPLE_CLOCKS  = 4;
	localparam int CONVERT_CLOCKS = 12;
	localparam logic [4:0] TOTAL_CLOCKS = 5'h10;

	typedef enum logic [2:0] {
		SRC_EXTERNAL = 3'h0,
		SRC_SUPPLY   = 3'h1,
		SRC_AMP      = 3'h2
	} input_kind_type;

	typedef enum logic [2:0] {
		REF_SUPPLY   = 3'h1,
		REF_EXTERNAL = 3'h2,
		REF_BANDGAP  = 3'h4
	} ref_kind_type;

	typedef struct packed {
		input_kind_type kind;
		logic [2:0]     channel;
		logic [1:0]     scale_log2;
	} input_route_type;

	typedef struct packed {
		ref_kind_type kind;
		logic [2:0]   multiplier;
		logic         prohibited;
	} ref_route_type;
endpackage : adc_control_pkg

/* bench/tb_top.sv */
// Self-checking bench for the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                             clock;
	logic                             arst_n;
	logic [2:0]                       reg_addr;
	logic [7:0]                       reg_wdata;
	logic                             reg_write;
	logic                             reg_read;
	logic [7:0]                       reg_rdata;
	logic                             core_bit;
	logic [7:0]                       pin_analog_select;
	logic [7:0]                       pin_digital_disable;
	logic                             converter_enable;
	logic                             converter_reset;
	logic                             converter_clock;
	logic                             sample_phase;
	logic                             conversion_busy_flag;
	logic                             interrupt_request;
	adc_control_pkg::input_route_type input_route;
	adc_control_pkg::ref_route_type   ref_route;
	logic                             amplifier_enable;
	logic                             bandgap_buffer_enable;
	logic                             amp_input_bandgap;
	int                               n_errors = 0;
	int                               n_tests = 0;
	int                               cycles = 0;
	int                               n_irq = 0;
	int                               ib = 0;

	adc_control_sequencer adc_control_sequencer_inst (
		.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .core_bit(core_bit),
		.pin_analog_select(pin_analog_select),
		.pin_digital_disable(pin_digital_disable),
		.converter_enable(converter_enable), .converter_reset(converter_reset),
		.converter_clock(converter_clock), .sample_phase(sample_phase),
		.conversion_busy_flag(conversion_busy_flag),
		.interrupt_request(interrupt_request), .input_route(input_route),
		.ref_route(ref_route), .amplifier_enable(amplifier_enable),
		.bandgap_buffer_enable(bandgap_buffer_enable),
		.amp_input_bandgap(amp_input_bandgap)
	);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic conclude;
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : conclude

	// Ceiling well above the longest conversion sweep
	// Falling edge keeps the pulse count clear of the launching edge
	always @(negedge clock) begin
		cycles++;
		if (interrupt_request === 1'b1)
			n_irq++;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr

	// Read data is only valid in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask : rdc

	task automatic conv(input logic [2:0] code, input logic b, input logic al);
		int         np;
		int         ns;
		int         t1;
		int         t2;
		int         cyc;
		logic [11:0] r;
		np = 0;
		ns = 0;
		t1 = 0;
		t2 = 0;
		cyc = 0;
		r = b ? 12'hFFF : 12'h000;
		wr(adc_control_pkg::ADDR_SRC_CLK, {5'h00, code});
		core_bit <= b;
		wr(adc_control_pkg::ADDR_CTRL_MAIN, {3'b101, al, 4'h0});
		wr(adc_control_pkg::ADDR_CTRL_MAIN, {3'b001, al, 4'h0});
		while (interrupt_request !== 1'b1 && cyc < 3000) begin
			@(negedge clock);
			cyc++;
			if (converter_clock === 1'b1) begin
				np++;
				if (np == 2)
					t1 = cyc;
				if (np == 3)
					t2 = cyc;
				if (sample_phase === 1'b1)
					ns++;
				chk({7'h00, conversion_busy_flag}, {7'h00, np != 16});
			end
		end
		chk(8'(np), 8'h10);
		chk(8'(ns), 8'h04);
		chk(8'(t2 - t1), 8'(1 << code));
		@(negedge clock);
		chk({6'h00, interrupt_request, conversion_busy_flag}, 8'h00);
		rdc(adc_control_pkg::ADDR_RESULT_HIGH, al ? {4'h0, r[11:8]} : r[11:4]);
		rdc(adc_control_pkg::ADDR_RESULT_LOW, al ? r[7:0] : {r[3:0], 4'h0});
	endtask : conv

	initial begin
		logic [2:0] ek;
		arst_n = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
		core_bit = 1'b0;
		pin_analog_select = 8'h00;
		repeat (10) @(negedge clock);
		chk({6'h00, converter_reset, conversion_busy_flag}, 8'h02);
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		rdc(adc_control_pkg::ADDR_CTRL_MAIN, adc_control_pkg::CTRL_RESET);
		rdc(adc_control_pkg::ADDR_SRC_CLK, 8'h00);
		rdc(adc_control_pkg::ADDR_REF_AMP, 8'h00);
		rdc(3'h7, 8'h00);
		wr(adc_control_pkg::ADDR_SRC_CLK, 8'hFF);
		rdc(adc_control_pkg::ADDR_SRC_CLK, 8'hE7);
		wr(adc_control_pkg::ADDR_REF_AMP, 8'hFF);
		rdc(adc_control_pkg::ADDR_REF_AMP, 8'hCF);
		chk({5'h00, amplifier_enable, bandgap_buffer_enable, amp_input_bandgap}, 8'h07);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h5F);
		rdc(adc_control_pkg::ADDR_CTRL_MAIN, 8'h17);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h05);
		for (int i = 0; i < 8; i++) begin
			wr(adc_control_pkg::ADDR_SRC_CLK, {i[2:0], 5'h00});
			repeat (2) @(negedge clock);
			ek = (i == 0 || i == 4) ? adc_control_pkg::SRC_EXTERNAL :
				(i < 4 ? adc_control_pkg::SRC_SUPPLY : adc_control_pkg::SRC_AMP);
			chk({5'h00, input_route.kind}, {5'h00, ek});
			if (ek == adc_control_pkg::SRC_EXTERNAL)
				chk({5'h00, input_route.channel}, 8'h05);
			else
				chk({6'h00, input_route.scale_log2}, {6'h00, i[1:0] - 2'h1});
		end
		for (int i = 0; i < 16; i++) begin
			wr(adc_control_pkg::ADDR_REF_AMP, {4'h8, i[3:0]});
			repeat (2) @(negedge clock);
			chk({7'h00, amp_input_bandgap}, {7'h00, i[3]});
			chk({7'h00, ref_route.prohibited}, {7'h00, i == 9});
			if (i != 9) begin
				ek = (i >= 1 && i <= 4) ? adc_control_pkg::REF_EXTERNAL :
					((i >= 10 && i <= 12) ? adc_control_pkg::REF_BANDGAP :
					adc_control_pkg::REF_SUPPLY);
				chk({5'h00, ref_route.kind}, {5'h00, ek});
				if (ek != adc_control_pkg::REF_SUPPLY)
					chk({5'h00, ref_route.multiplier}, 8'(i[3] ? i - 8 : i));
			end
		end
		chk({6'h00, amplifier_enable, bandgap_buffer_enable}, 8'h02);
		@(posedge clock);
		pin_analog_select <= 8'hA5;
		repeat (3) @(negedge clock);
		chk(pin_digital_disable, 8'hA5);
		for (int c = 0; c < 8; c++)
			conv(c[2:0], c[0], c[1]);
		chk({7'h00, converter_enable}, 8'h01);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'hA0);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h20);
		repeat (20) @(negedge clock);
		chk({7'h00, conversion_busy_flag}, 8'h01);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'hA0);
		repeat (3) @(negedge clock);
		chk({6'h00, converter_reset, conversion_busy_flag}, 8'h02);
		ib = n_irq;
		repeat (200) @(negedge clock);
		chk(8'(n_irq - ib), 8'h00);
		conv(3'h5, 1'b1, 1'b0);
		wr(adc_control_pkg::ADDR_RESULT_HIGH, 8'h00);
		rdc(adc_control_pkg::ADDR_RESULT_HIGH, 8'hFF);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h00);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h80);
		wr(adc_control_pkg::ADDR_CTRL_MAIN, 8'h00);
		ib = n_irq;
		repeat (100) @(negedge clock);
		chk({6'h00, converter_enable, conversion_busy_flag}, 8'h00);
		chk(8'(n_irq - ib), 8'h00);
		rdc(adc_control_pkg::ADDR_RESULT_LOW, 8'hF0);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
